// File: rtl/fe_loop_ctrl.sv
// module: serial configuration controller with apb registers
//
// Design decisions made here: the register addresses and the APB register port.
module fe_loop_ctrl
   import fe_loop_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   fe_loop_if.ctrl link // serial link
);
   // =====================================================
   // apb decode
   logic access, wr, mapped, mappedSetup;
   logic [31:0] rdValue;

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == OFS_CTRL) || (a == OFS_TXDATA) ||
                 (a == OFS_STATUS) || (a == OFS_RX1) ||
                 (a == OFS_RX2) || (a == OFS_RX3);
   endfunction

   assign access = psel & penable;
   assign mapped = isMapped(paddr);
   assign wr = access & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign mappedSetup = psel & ~penable;

   // =====================================================
   // input synchronisers: returns[2:0], error, reference
   logic [7:0] pin, s1, s2, s3, held, prevHeld, next_held;
   localparam logic [7:0] PIN_RESET = 8'h18;

   assign pin = {3'b000, link.extRefDetectN, link.frontendErrorN,
                 link.loop3Return, link.loop2Return, link.loop1Return};

   always_comb begin
      next_held = settle(s2, s3, held);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s1 <= PIN_RESET;
         s2 <= PIN_RESET;
         s3 <= PIN_RESET;
         held <= PIN_RESET;
         prevHeld <= PIN_RESET;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         held <= next_held;
         prevHeld <= held;
      end
   end

   // =====================================================
   // registers and flags
   logic [2:0] enable, next_enable;
   logic progEnable, next_progEnable;
   frame_t txData, next_txData;
   logic errFlag, next_errFlag, refFlag, next_refFlag;
   logic startReq;

   assign startReq = wr & (paddr == OFS_CTRL) & pwdata[CTRL_START_BIT];

   always_comb begin
      next_enable = enable;
      next_progEnable = progEnable;
      next_txData = txData;
      if (wr && paddr == OFS_CTRL) begin
         next_enable = pwdata[CTRL_ENABLE_LSB +: 3];
         next_progEnable = pwdata[CTRL_PROGRAM_BIT];
      end
      if (wr && paddr == OFS_TXDATA) begin
         next_txData = pwdata;
      end
      // set wins over the write-one clear
      next_errFlag = errFlag;
      next_refFlag = refFlag;
      if (wr && paddr == OFS_STATUS) begin
         next_errFlag = errFlag & ~pwdata[ST_ERRFLAG_BIT];
         next_refFlag = refFlag & ~pwdata[ST_REFFLAG_BIT];
      end
      if (!held[3]) begin
         next_errFlag = 1'b1;
      end
      if (held[4] != prevHeld[4]) begin
         next_refFlag = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable <= ENABLE_RESET;
         progEnable <= 1'b0;
         txData <= '0;
         errFlag <= 1'b0;
         refFlag <= 1'b0;
      end else begin
         enable <= next_enable;
         progEnable <= next_progEnable;
         txData <= next_txData;
         errFlag <= next_errFlag;
         refFlag <= next_refFlag;
      end
   end

   assign link.gateArrayProgramN = ~progEnable;

   // =====================================================
   // shift engine
   ctrl_state_t state, next_state;
   logic [7:0] halfCnt, next_halfCnt;
   logic [5:0] bitCnt, next_bitCnt;
   frame_t shiftReg, next_shiftReg, frame, next_frame;
   logic [2:0] active, next_active, sclk, next_sclk;
   logic [2:0] match, next_match;
   logic dout, next_dout, latchN, next_latchN;
   logic [2:0][FRAME_BITS-1:0] rx, next_rx, lastSent, next_lastSent;

   always_comb begin
      next_state = state;
      next_halfCnt = halfCnt + 8'h01;
      next_bitCnt = bitCnt;
      next_shiftReg = shiftReg;
      next_frame = frame;
      next_active = active;
      next_sclk = sclk;
      next_match = match;
      next_dout = dout;
      next_latchN = latchN;
      next_rx = rx;
      next_lastSent = lastSent;
      unique case (state)
         ST_IDLE: begin
            next_halfCnt = 8'h00;
            if (startReq) begin
               next_shiftReg = txData;
               next_frame = txData;
               next_active = next_enable;
               next_dout = txData[FRAME_BITS-1];
               next_bitCnt = 6'h00;
               next_state = ST_LOW;
            end
         end
         ST_LOW: begin
            if (halfCnt == SCLK_HALF_CYCLES - 8'h01) begin
               for (int i = 0; i < NUM_LOOPS; i++) begin
                  if (active[i]) begin
                     next_rx[i] = {rx[i][FRAME_BITS-2:0], held[i]};
                  end
               end
               next_sclk = active;
               next_halfCnt = 8'h00;
               next_state = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (halfCnt == SCLK_HALF_CYCLES - 8'h01) begin
               // one bit per serial clock
               next_sclk = 3'h0;
               next_halfCnt = 8'h00;
               next_shiftReg = {shiftReg[FRAME_BITS-2:0], 1'b0};
               next_dout = shiftReg[FRAME_BITS-2];
               next_bitCnt = bitCnt + 6'h01;
               next_state = (bitCnt == LAST_BIT) ? ST_GAP : ST_LOW;
            end
         end
         ST_GAP: begin
            if (halfCnt == SCLK_HALF_CYCLES - 8'h01) begin
               next_latchN = 1'b0;
               next_halfCnt = 8'h00;
               next_state = ST_LATCH;
            end
         end
         ST_LATCH: begin
            if (halfCnt == LATCH_CYCLES - 8'h01) begin
               next_latchN = 1'b1;
               for (int i = 0; i < NUM_LOOPS; i++) begin
                  if (active[i]) begin
                     next_match[i] = (rx[i] == lastSent[i]);
                     next_lastSent[i] = frame;
                  end else begin
                     next_match[i] = 1'b0;
                  end
               end
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_sclk = 3'h0;
            next_latchN = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         halfCnt <= 8'h00;
         bitCnt <= 6'h00;
         shiftReg <= '0;
         frame <= '0;
         active <= 3'h0;
         sclk <= 3'h0;
         match <= 3'h0;
         dout <= 1'b0;
         latchN <= 1'b1;
         rx <= '0;
         lastSent <= '0;
      end else begin
         state <= next_state;
         halfCnt <= next_halfCnt;
         bitCnt <= next_bitCnt;
         shiftReg <= next_shiftReg;
         frame <= next_frame;
         active <= next_active;
         sclk <= next_sclk;
         match <= next_match;
         dout <= next_dout;
         latchN <= next_latchN;
         rx <= next_rx;
         lastSent <= next_lastSent;
      end
   end

   assign link.loop1SerialClock = sclk[0];
   assign link.loop2SerialClock = sclk[1];
   assign link.loop3SerialClock = sclk[2];
   assign link.configSerialOut = dout;
   assign link.configLatchN = latchN;

   // =====================================================
   // read data, captured in the setup cycle
   always_comb begin
      rdValue = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL: begin
            rdValue[CTRL_ENABLE_LSB +: 3] = enable;
            rdValue[CTRL_PROGRAM_BIT] = progEnable;
         end
         OFS_TXDATA: rdValue = txData;
         OFS_STATUS: begin
            rdValue[ST_BUSY_BIT] = (state != ST_IDLE);
            rdValue[ST_MATCH_LSB +: 3] = match;
            rdValue[ST_ERRFLAG_BIT] = errFlag;
            rdValue[ST_REFFLAG_BIT] = refFlag;
            rdValue[ST_ERRLINE_BIT] = ~held[3];
            rdValue[ST_REFPRES_BIT] = ~held[4];
         end
         OFS_RX1: rdValue = rx[0];
         OFS_RX2: rdValue = rx[1];
         OFS_RX3: rdValue = rx[2];
         default: rdValue = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (mappedSetup) begin
         prdata <= rdValue;
      end
   end
endmodule // fe_loop_ctrl

// File: rtl/fe_loop_pkg.sv
// package: constants, types and helpers for the front-end config loop
package fe_loop_pkg;
   // =====================================================
   // sizes and timing
   localparam int NUM_LOOPS = 3;
   localparam int FRAME_BITS = 32;
   localparam int STAGE_BITS = 16;
   localparam int CLOCK_NS = 50;
   localparam int SCLK_HALF_NS = 400;
   localparam int LATCH_PULSE_NS = 400;
   localparam int ERR_PULSE_NS = 1000;
   localparam logic [7:0] SCLK_HALF_CYCLES =
      8'((SCLK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] LATCH_CYCLES =
      8'((LATCH_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [7:0] ERR_PULSE_CYCLES =
      8'((ERR_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);

   // =====================================================
   // controller register map (byte offsets)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXDATA = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_RX1 = 8'h0c;
   localparam logic [7:0] OFS_RX2 = 8'h10;
   localparam logic [7:0] OFS_RX3 = 8'h14;

   // ctrl fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ENABLE_LSB = 1;
   localparam int CTRL_PROGRAM_BIT = 4;
   localparam logic [2:0] ENABLE_RESET = 3'h7;
   // status fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_MATCH_LSB = 1;
   localparam int ST_ERRFLAG_BIT = 4;
   localparam int ST_REFFLAG_BIT = 5;
   localparam int ST_ERRLINE_BIT = 6;
   localparam int ST_REFPRES_BIT = 7;

   // =====================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOW = 3'b001,
      ST_HIGH = 3'b010,
      ST_GAP = 3'b011,
      ST_LATCH = 3'b100
   } ctrl_state_t;

   typedef logic [FRAME_BITS-1:0] frame_t;

   // =====================================================
   // glitch filter: a bit changes once 2nd and 3rd flops agree
   function automatic logic [7:0] settle(input logic [7:0] s2,
                                         input logic [7:0] s3,
                                         input logic [7:0] held);
      settle = (s2 & s3) | (held & (s2 | s3));
   endfunction
endpackage

// File: rtl/fe_loop_if.sv
// interface: serial configuration link between controller and front end
interface fe_loop_if;
   logic loop1SerialClock;
   logic loop2SerialClock;
   logic loop3SerialClock;
   logic configSerialOut;
   logic loop1MidChain;
   logic loop2MidChain;
   logic loop3MidChain;
   logic loop1Return;
   logic loop2Return;
   logic loop3Return;
   logic configLatchN;
   logic errorOut;
   logic errorDriveEn;
   logic frontendErrorN;
   logic extRefDetectN;
   logic gateArrayProgramN;

   // open-drain error line, pulled up when nobody drives
   assign frontendErrorN = errorDriveEn ? errorOut : 1'b1;

   modport ctrl (
      output loop1SerialClock, loop2SerialClock, loop3SerialClock,
      output configSerialOut, configLatchN, gateArrayProgramN,
      input loop1Return, loop2Return, loop3Return,
      input frontendErrorN, extRefDetectN
   );

   modport fe (
      input loop1SerialClock, loop2SerialClock, loop3SerialClock,
      input configSerialOut, configLatchN, gateArrayProgramN,
      output loop1MidChain, loop2MidChain, loop3MidChain,
      output loop1Return, loop2Return, loop3Return,
      output errorOut, errorDriveEn, extRefDetectN
   );
endinterface

// File: rtl/fe_loop_frontend.sv
// module: front-end stage pair for each loop, reference detect, error
module fe_loop_frontend
   import fe_loop_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic reset_n, // async reset, active low
   fe_loop_if.fe link, // serial link
   input wire logic [2:0] attention, // per-loop stage needs attention
   input wire logic refPresent, // external reference present
   output logic [2:0][FRAME_BITS-1:0] loopConfig, // latched per loop
   output logic programMode // gate arrays in programming mode
);
   // =====================================================
   // pin synchronisers: clocks[2:0], data, latch, program
   logic [7:0] pin, s1, s2, s3, held, prevHeld, next_held;
   localparam logic [7:0] PIN_RESET = 8'h30;

   assign pin = {2'b00, link.gateArrayProgramN, link.configLatchN,
                 link.configSerialOut, link.loop3SerialClock,
                 link.loop2SerialClock, link.loop1SerialClock};

   always_comb begin
      next_held = settle(s2, s3, held);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s1 <= PIN_RESET;
         s2 <= PIN_RESET;
         s3 <= PIN_RESET;
         held <= PIN_RESET;
         prevHeld <= PIN_RESET;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         held <= next_held;
         prevHeld <= held;
      end
   end

   // =====================================================
   // two stages per loop
   logic [2:0][STAGE_BITS-1:0] stageA, stageB, next_stageA, next_stageB;
   logic [2:0][FRAME_BITS-1:0] next_loopConfig;
   logic latchFall;

   assign latchFall = prevHeld[4] & ~held[4];
   assign programMode = ~held[5];

   always_comb begin
      next_stageA = stageA;
      next_stageB = stageB;
      next_loopConfig = loopConfig;
      for (int i = 0; i < NUM_LOOPS; i++) begin
         if (held[i] & ~prevHeld[i]) begin
            // data passes stage A then stage B
            next_stageA[i] = {stageA[i][STAGE_BITS-2:0], held[3]};
            next_stageB[i] = {stageB[i][STAGE_BITS-2:0],
                              stageA[i][STAGE_BITS-1]};
         end
         if (latchFall) begin
            next_loopConfig[i] = {stageB[i], stageA[i]};
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stageA <= '0;
         stageB <= '0;
         loopConfig <= '0;
      end else begin
         stageA <= next_stageA;
         stageB <= next_stageB;
         loopConfig <= next_loopConfig;
      end
   end

   assign link.loop1MidChain = stageA[0][STAGE_BITS-1];
   assign link.loop2MidChain = stageA[1][STAGE_BITS-1];
   assign link.loop3MidChain = stageA[2][STAGE_BITS-1];
   assign link.loop1Return = stageB[0][STAGE_BITS-1];
   assign link.loop2Return = stageB[1][STAGE_BITS-1];
   assign link.loop3Return = stageB[2][STAGE_BITS-1];

   // =====================================================
   // reference detect and error line
   logic detectN, next_detectN, errDrive, next_errDrive;
   logic [7:0] pulseCnt, next_pulseCnt;

   always_comb begin
      next_detectN = ~refPresent;
      next_pulseCnt = pulseCnt;
      if (next_detectN != detectN) begin
         next_pulseCnt = ERR_PULSE_CYCLES;
      end else if (pulseCnt != 8'h00) begin
         next_pulseCnt = pulseCnt - 8'h01;
      end
      next_errDrive = (|attention) | (next_pulseCnt != 8'h00);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         detectN <= 1'b1;
         pulseCnt <= 8'h00;
         errDrive <= 1'b0;
      end else begin
         detectN <= next_detectN;
         pulseCnt <= next_pulseCnt;
         errDrive <= next_errDrive;
      end
   end

   assign link.extRefDetectN = detectN;
   assign link.errorOut = 1'b0;
   assign link.errorDriveEn = errDrive;
endmodule // fe_loop_frontend

// File: tb/fe_loop_checker.sv
// checker: timing relations on the serial configuration link
module fe_loop_checker (
   input wire logic clock, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic [2:0] attention, // stage attention requests
   input wire logic loop1SerialClock, // loop 1 clock
   input wire logic loop2SerialClock, // loop 2 clock
   input wire logic loop3SerialClock, // loop 3 clock
   input wire logic configSerialOut, // serial data
   input wire logic configLatchN, // latch strobe
   input wire logic errorDriveEn, // error line driver on
   input wire logic frontendErrorN, // resolved error line
   input wire logic extRefDetectN // reference detect
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================
   // properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   logic anyClock;
   assign anyClock = loop1SerialClock | loop2SerialClock | loop3SerialClock;

   a_latch_no_shift: assert property (
      !configLatchN |-> !anyClock)
      else $error("serial clock high during latch pulse");
   a_latch_pulse_len: assert property (
      $fell(configLatchN) |-> !configLatchN [*8] ##1 configLatchN)
      else $error("latch pulse length wrong");
   a_latch_after_gap: assert property (
      $fell(configLatchN) |-> !$past(anyClock, 1) && !$past(anyClock, 8))
      else $error("latch pulse without idle gap");
   a_data_clock_low: assert property (
      $changed(configSerialOut) |-> !anyClock)
      else $error("serial data changed while a clock was high");
   a_clock_half_len: assert property (
      $rose(loop1SerialClock) |-> loop1SerialClock [*8] ##1 !loop1SerialClock)
      else $error("loop 1 clock high phase length wrong");
   a_ref_forces_err: assert property (
      $changed(extRefDetectN) |-> ##[0:6] !frontendErrorN)
      else $error("reference edge did not pull the error line low");
   a_err_pulse_min: assert property (
      $rose(errorDriveEn) |-> errorDriveEn [*8])
      else $error("error drive pulse too short");
   a_err_drive_low: assert property (
      (|attention) |=> !frontendErrorN)
      else $error("attention did not pull the error line low");

   c_latch: cover property ($fell(configLatchN));
   c_err: cover property ($rose(errorDriveEn));
   c_ref: cover property ($fell(extRefDetectN));
endmodule // fe_loop_checker

// File: tb/tb.sv
// testbench: controller and front end joined over the link
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fe_loop_pkg::*;

   // =====================================================
   // signals and instances
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, programMode;
   logic [2:0] attention = 3'h0;
   logic refPresent = 1'b0;
   logic [2:0][FRAME_BITS-1:0] cfg;
   logic [2:0] mid;
   int failures = 0, compares = 0, cycles = 0;

   always #25 clock = ~clock;

   fe_loop_if u_fe_loop_if ();
   fe_loop_ctrl u_fe_loop_ctrl (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(u_fe_loop_if));
   fe_loop_frontend u_fe_loop_frontend (.clock(clock), .reset_n(reset_n),
      .link(u_fe_loop_if), .attention(attention), .refPresent(refPresent),
      .loopConfig(cfg), .programMode(programMode));
   assign mid = {u_fe_loop_if.loop3MidChain, u_fe_loop_if.loop2MidChain,
                 u_fe_loop_if.loop1MidChain};
   fe_loop_checker u_fe_loop_checker (.clock(clock), .reset_n(reset_n),
      .attention(attention),
      .loop1SerialClock(u_fe_loop_if.loop1SerialClock),
      .loop2SerialClock(u_fe_loop_if.loop2SerialClock),
      .loop3SerialClock(u_fe_loop_if.loop3SerialClock),
      .configSerialOut(u_fe_loop_if.configSerialOut),
      .configLatchN(u_fe_loop_if.configLatchN),
      .errorDriveEn(u_fe_loop_if.errorDriveEn),
      .frontendErrorN(u_fe_loop_if.frontendErrorN),
      .extRefDetectN(u_fe_loop_if.extRefDetectN));

   // =====================================================
   // tasks
   task automatic final_report();
      if (failures == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input logic [31:0] tx, input logic [2:0] en);
      logic [31:0] r;
      logic e;
      apb(1'b1, OFS_TXDATA, tx, r, e);
      apb(1'b1, OFS_CTRL, {27'h0, 1'b0, en, 1'b1}, r, e);
      r = 32'h1;
      while (r[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0, r, e);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         final_report();
      end
   end

   // =====================================================
   // register table: write flag, address, data, expected read, error
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } row_t;
   row_t rows [8] = '{
      '{1'b0, OFS_CTRL, 32'h0, 32'h0000000e, 1'b0},
      '{1'b0, OFS_STATUS, 32'h0, 32'h00000000, 1'b0},
      '{1'b1, OFS_TXDATA, 32'ha5c30f96, 32'h0, 1'b0},
      '{1'b0, OFS_TXDATA, 32'h0, 32'ha5c30f96, 1'b0},
      '{1'b1, OFS_RX1, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, OFS_RX1, 32'h0, 32'h00000000, 1'b0},
      '{1'b1, 8'h18, 32'h12345678, 32'h0, 1'b1},
      '{1'b0, 8'h1c, 32'h0, 32'h00000000, 1'b1}};

   // =====================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic e;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, r, e);
         chk("pslverr", 32'(rows[i].e), 32'(e));
         if (!rows[i].w) chk("prdata", rows[i].x, r);
      end
      // two full frames: returns carry the previous frame
      frame(32'h8000_0001, 3'h7);
      frame(32'h5a5a_c3c3, 3'h7);
      apb(1'b0, OFS_RX1, 32'h0, r, e);
      chk("rx1", 32'h8000_0001, r);
      apb(1'b0, OFS_RX3, 32'h0, r, e);
      chk("rx3", 32'h8000_0001, r);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("match", 32'he, r & 32'hf);
      for (int i = 0; i < 3; i++) chk("cfg", 32'h5a5a_c3c3, cfg[i]);
      chk("mid", 32'h7, 32'(mid));
      // only loop 1 enabled
      frame(32'h0f0f_1234, 3'h1);
      apb(1'b0, OFS_RX2, 32'h0, r, e);
      chk("rx2 kept", 32'h8000_0001, r);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("match one", 32'h2, r & 32'hf);
      chk("cfg1", 32'h0f0f_1234, cfg[0]);
      chk("cfg2", 32'h5a5a_c3c3, cfg[1]);
      chk("mid one", 32'h6, 32'(mid));
      // stage attention drives the error line and the flag
      attention <= 3'h2;
      repeat (10) @(posedge clock);
      chk("err line", 32'h0, 32'(u_fe_loop_if.frontendErrorN));
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("err flags", 32'h50, r & 32'h50);
      attention <= 3'h0;
      repeat (10) @(posedge clock);
      apb(1'b1, OFS_STATUS, 32'h10, r, e);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("err cleared", 32'h0, r & 32'h50);
      // reference arrives then leaves
      refPresent <= 1'b1;
      repeat (10) @(posedge clock);
      chk("detect", 32'h0, 32'(u_fe_loop_if.extRefDetectN));
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("ref flags", 32'hb0, r & 32'hb0);
      repeat (30) @(posedge clock);
      apb(1'b1, OFS_STATUS, 32'h30, r, e);
      refPresent <= 1'b0;
      repeat (8) @(posedge clock);
      chk("err on leave", 32'h0, 32'(u_fe_loop_if.frontendErrorN));
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("ref flag", 32'h20, r & 32'ha0);
      // programming mode
      apb(1'b1, OFS_CTRL, 32'h1e, r, e);
      repeat (6) @(posedge clock);
      chk("prog line", 32'h0, 32'(u_fe_loop_if.gateArrayProgramN));
      chk("prog mode", 32'h1, 32'(programMode));
      apb(1'b1, OFS_CTRL, 32'he, r, e);
      repeat (6) @(posedge clock);
      chk("prog off", 32'h0, 32'(programMode));
      // reset in mid-run
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      chk("latch idle", 32'h1, 32'(u_fe_loop_if.configLatchN));
      chk("cfg reset", 32'h0, cfg[0]);
      apb(1'b0, OFS_CTRL, 32'h0, r, e);
      chk("ctrl reset", 32'he, r);
      final_report();
   end
endmodule // tb
